// >>> core/acbd_core.v
`timescale 1ns/1ps
`include "acbd_defs.vh"
// serial control byte decoder and conversion sequencer
module acbd_core #(
   parameter EIGHT_CH = 1,
   parameter [15:0] STEP_CYCLES = `ACBD_INT_STEP_CYC
) (
   input wire clk,
   input wire nrst,
   input wire cs_n_pin,
   input wire sclk_pin,
   input wire din_pin,
   input wire cmp_hi_pin,
   input wire in_neg_pin,
   output reg dout_q,
   output reg dout_oe_q,
   output reg conversion_strobe_q,
   output reg conversion_strobe_oe_q,
   output reg [2:0] pos_chan_q,
   output reg [2:0] neg_chan_q,
   output reg neg_is_return_q,
   output reg coding_unipolar_q,
   output reg single_ended_q,
   output reg powered_q,
   output reg ext_clock_q,
   output reg track_q,
   output reg [7:0] trial_q
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_STRB = 3'h1;
   localparam [2:0] ST_EDATA = 3'h2;
   localparam [2:0] ST_ICONV = 3'h3;
   localparam [2:0] ST_IREAD = 3'h4;

   reg [1:0] rst_q;
   wire rst_n;
   wire [4:0] pins_s;
   wire cs_n_s;
   wire sclk_s;
   wire din_s;
   wire cmp_s;
   wire neg_s;
   reg sclk_p_q;
   reg cs_n_p_q;
   reg [3:0] rx_cnt_q;
   reg [7:0] rx_sh_q;
   reg [2:0] state_q;
   reg strb_cnt_q;
   reg [2:0] bit_q;
   reg [15:0] tick_q;
   reg [7:0] res_q;
   reg lead_q;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire [7:0] onehot;
   wire [7:0] trial_nx;
   wire force_zero;
   wire obit;
   wire [7:0] coded_res;
   wire [2:0] pos_nx;
   wire [2:0] neg_nx;

   // reset release through two flops
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // select enters inverted so a cleared synchroniser reads as deselected
   acbd_sync #(.WIDTH(5)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({~cs_n_pin, sclk_pin, din_pin, cmp_hi_pin, in_neg_pin}),
      .q(pins_s)
   );
   assign cs_n_s = ~pins_s[4];
   assign sclk_s = pins_s[3];
   assign din_s = pins_s[2];
   assign cmp_s = pins_s[1];
   assign neg_s = pins_s[0];

   // shift clock edges, only while selected
   assign sclk_rise = sclk_s & ~sclk_p_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_p_q & ~cs_n_s;
   assign cs_fall = ~cs_n_s & cs_n_p_q;

   // successive approximation step on the current trial bit
   assign onehot = 8'h01 << bit_q;
   assign trial_nx = (trial_q & ~onehot) | (cmp_s ? onehot : 8'h00)
      | ((bit_q != 3'h0) ? (onehot >> 1) : 8'h00);
   assign force_zero = coding_unipolar_q & ~single_ended_q & neg_s;
   // bipolar: flip the msb of offset binary for two's complement
   assign obit = force_zero ? 1'b0 :
      (((bit_q == `ACBD_RES_MSB) && !coding_unipolar_q) ? ~cmp_s : cmp_s);
   assign coded_res = force_zero ? 8'h00 :
      {trial_nx[7] ^ ~coding_unipolar_q, trial_nx[6:0]};

   // channel routing from the freshly received byte
   generate
      if (EIGHT_CH != 0)
      begin : g_eight
         assign pos_nx = {rx_sh_q[`ACBD_BIT_SELHI], rx_sh_q[`ACBD_BIT_SELLO],
            rx_sh_q[`ACBD_BIT_POLSEL]};
         assign neg_nx = {rx_sh_q[`ACBD_BIT_SELHI], rx_sh_q[`ACBD_BIT_SELLO],
            ~rx_sh_q[`ACBD_BIT_POLSEL]};
      end
      else
      begin : g_four
         assign pos_nx = {1'b0, rx_sh_q[`ACBD_BIT_SELHI],
            rx_sh_q[`ACBD_BIT_POLSEL]};
         assign neg_nx = {1'b0, rx_sh_q[`ACBD_BIT_SELHI],
            ~rx_sh_q[`ACBD_BIT_POLSEL]};
      end
   endgenerate

   // serial receiver, conversion sequencer and output drivers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_p_q <= 1'b0;
         cs_n_p_q <= 1'b1;
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         state_q <= ST_IDLE;
         strb_cnt_q <= 1'b0;
         bit_q <= 3'h0;
         tick_q <= 16'h0000;
         res_q <= 8'h00;
         lead_q <= 1'b0;
         dout_q <= 1'b0;
         dout_oe_q <= 1'b0;
         conversion_strobe_q <= `ACBD_RST_STROBE;
         conversion_strobe_oe_q <= 1'b1;
         pos_chan_q <= 3'h0;
         neg_chan_q <= 3'h0;
         neg_is_return_q <= 1'b1;
         coding_unipolar_q <= `ACBD_RST_UNI;
         single_ended_q <= `ACBD_RST_SINGLE;
         powered_q <= `ACBD_RST_POWER;
         ext_clock_q <= `ACBD_RST_EXTCLK;
         track_q <= 1'b0;
         trial_q <= 8'h00;
      end
      else
      begin
         sclk_p_q <= sclk_s;
         cs_n_p_q <= cs_n_s;
         // internal clock conversion runs regardless of the link
         if (state_q == ST_ICONV)
         begin
            if (tick_q == 16'h0000)
            begin
               tick_q <= STEP_CYCLES - 16'h0001;
               trial_q <= trial_nx;
               bit_q <= bit_q - 3'h1;
               if (bit_q == 3'h0)
               begin
                  res_q <= coded_res;
                  conversion_strobe_q <= 1'b1;
                  lead_q <= 1'b1;
                  state_q <= ST_IREAD;
               end
            end
            else
               tick_q <= tick_q - 16'h0001;
         end
         if (cs_n_s)
         begin
            // deselected: release data out, and the strobe in external clock mode only, drop any partial byte
            rx_cnt_q <= 4'h0;
            track_q <= 1'b0;
            dout_oe_q <= 1'b0;
            dout_q <= 1'b0;
            if (ext_clock_q)
            begin
               conversion_strobe_oe_q <= 1'b0;
               conversion_strobe_q <= 1'b0;
               if (state_q == ST_STRB || state_q == ST_EDATA)
                  state_q <= ST_IDLE;
            end
         end
         else
         begin
            dout_oe_q <= 1'b1;
            conversion_strobe_oe_q <= 1'b1;
            if (cs_fall && ext_clock_q)
               conversion_strobe_q <= 1'b0;
         end
         // rising edge: collect control bits, not in the strobe window
         if (sclk_rise && state_q != ST_STRB)
         begin
            if (rx_cnt_q == 4'h0)
            begin
               if (din_s)
               begin
                  rx_cnt_q <= 4'h1;
                  rx_sh_q <= {rx_sh_q[6:0], din_s};
               end
            end
            else if (rx_cnt_q < `ACBD_BYTE_BITS)
            begin
               rx_cnt_q <= rx_cnt_q + 4'h1;
               rx_sh_q <= {rx_sh_q[6:0], din_s};
            end
         end
         // falling edge: track/hold, strobe and result bits
         if (sclk_fall)
         begin
            if (rx_cnt_q == `ACBD_TRACK_BIT)
               track_q <= 1'b1;
            if (rx_cnt_q == `ACBD_BYTE_BITS)
            begin
               // byte complete: latch fields, start a new conversion
               rx_cnt_q <= 4'h0;
               track_q <= 1'b0;
               pos_chan_q <= pos_nx;
               neg_chan_q <= neg_nx;
               neg_is_return_q <= rx_sh_q[`ACBD_BIT_MODE];
               single_ended_q <= rx_sh_q[`ACBD_BIT_MODE];
               coding_unipolar_q <= rx_sh_q[`ACBD_BIT_CODING];
               powered_q <= rx_sh_q[`ACBD_BIT_POWER];
               ext_clock_q <= rx_sh_q[`ACBD_BIT_CLKSEL];
               trial_q <= 8'h80;
               bit_q <= `ACBD_RES_MSB;
               dout_q <= 1'b0;
               strb_cnt_q <= 1'b0;
               if (rx_sh_q[`ACBD_BIT_CLKSEL])
               begin
                  conversion_strobe_q <= 1'b1;
                  state_q <= ST_STRB;
               end
               else
               begin
                  conversion_strobe_q <= 1'b0;
                  tick_q <= STEP_CYCLES - 16'h0001;
                  state_q <= ST_ICONV;
               end
            end
            else
            begin
               case (state_q)
                  ST_STRB:
                  begin
                     if (strb_cnt_q)
                     begin
                        // second period over: strobe low, msb out
                        conversion_strobe_q <= 1'b0;
                        dout_q <= obit;
                        trial_q <= trial_nx;
                        bit_q <= bit_q - 3'h1;
                        state_q <= ST_EDATA;
                     end
                     else
                        strb_cnt_q <= 1'b1;
                  end
                  ST_EDATA:
                  begin
                     dout_q <= obit;
                     trial_q <= trial_nx;
                     bit_q <= bit_q - 3'h1;
                     if (bit_q == 3'h0)
                        state_q <= ST_IDLE;
                  end
                  ST_IREAD:
                  begin
                     // one zero edge, then stored result msb first
                     if (lead_q)
                     begin
                        lead_q <= 1'b0;
                        dout_q <= 1'b0;
                     end
                     else
                     begin
                        dout_q <= res_q[7];
                        res_q <= {res_q[6:0], 1'b0};
                     end
                  end
                  ST_ICONV:
                     dout_q <= 1'b0;
                  default:
                     dout_q <= 1'b0; // zeros once the result is out
               endcase
            end
         end
      end
   end
endmodule // acbd_core

// >>> core/acbd_defs.vh
// What this block does
// - first one after select low starts byte
// - bits 6..4 select the input channel
// - bit 3 one unipolar, zero bipolar
// - bit 2 one single-ended, zero differential
// - bit 1 one operational, zero power-down
// - bit 0 one external clock, zero internal
// - eight-channel single-ended index is {high,low,polarity}
// - eight-channel differential pair, polarity bit swaps
// - four-channel variant ignores low select bit
// - unipolar differential negative input gives zero
// - strobe high two periods before result MSB
// - back-to-back external conversion takes ten clocks
// - strobe and data change on falling edges; the internal clock strobe rises when the conversion ends
// - data input sampled on rising edges
// - track after sixth bit, hold after eighth
// - eight result bits on falling edges, MSB first
// - unipolar straight binary, bipolar two's complement
`ifndef ACBD_DEFS_VH
`define ACBD_DEFS_VH

// control byte field positions
`define ACBD_BIT_POLSEL 6
`define ACBD_BIT_SELHI 5
`define ACBD_BIT_SELLO 4
`define ACBD_BIT_CODING 3
`define ACBD_BIT_MODE 2
`define ACBD_BIT_POWER 1
`define ACBD_BIT_CLKSEL 0

// frame bit counts
`define ACBD_BYTE_BITS 4'h8
`define ACBD_TRACK_BIT 4'h6
`define ACBD_RES_MSB 3'h7

// reset values: internal clock mode, strobe high, powered
`define ACBD_RST_STROBE 1'b1
`define ACBD_RST_EXTCLK 1'b0
`define ACBD_RST_POWER 1'b1
`define ACBD_RST_UNI 1'b1
`define ACBD_RST_SINGLE 1'b1

// timing
`define ACBD_CLK_NS 4
`define ACBD_INT_CONV_NS 25000
`define ACBD_INT_STEP_CYC 16'h030D // conversion time over clock, per step

`endif

// >>> core/acbd_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin inputs
module acbd_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule // acbd_sync

// >>> sim/acbd_core_asserts.sv
`timescale 1ns/1ps
// pin-level checks on the decoder
module acbd_core_asserts (
   input wire clk,
   input wire nrst,
   input wire cs_n_pin,
   input wire sclk_pin,
   input wire dout_q,
   input wire dout_oe_q,
   input wire conversion_strobe_q,
   input wire [2:0] pos_chan_q,
   input wire [2:0] neg_chan_q,
   input wire neg_is_return_q,
   input wire single_ended_q,
   input wire ext_clock_q,
   input wire track_q
);
   reg [3:0] fall_cnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // shift clock falls seen while an external strobe stands
   always @(posedge clk or negedge nrst)
      if (!nrst)
         fall_cnt_q <= 4'h0;
      else if (!conversion_strobe_q || !ext_clock_q)
         fall_cnt_q <= 4'h0;
      else if ($fell(sclk_pin))
         fall_cnt_q <= fall_cnt_q + 4'h1;
   // enabled data out and external-mode strobe move only while the shift clock is low
   AST_DOUT_FALL: assert property ($changed(dout_q) && dout_oe_q
      |-> !sclk_pin) else $error("dout moved high");
   AST_STRB_FALL: assert property ($changed(conversion_strobe_q)
      && ext_clock_q && !cs_n_pin |-> !sclk_pin)
      else $error("strobe moved high");
   // external strobe spans exactly two shift clock falls
   AST_STRB_TWO: assert property ($fell(conversion_strobe_q)
      && ext_clock_q && !cs_n_pin |-> fall_cnt_q == 4'h2)
      else $error("strobe width");
   // hold starts as the strobe reports the clock mode
   AST_TRACK_END: assert property ($fell(track_q) && !cs_n_pin
      |-> conversion_strobe_q == ext_clock_q) else $error("hold edge");
   AST_TRACK_LEN: assert property ($rose(track_q) |-> !sclk_pin
      ##1 track_q [*8]) else $error("track too short");
   // fields stand while the external strobe is high
   AST_FIELD_HOLD: assert property (conversion_strobe_q && ext_clock_q
      && $past(conversion_strobe_q) && $past(ext_clock_q)
      |-> $stable({pos_chan_q, neg_chan_q, single_ended_q}))
      else $error("fields moved");
   // input routing follows the mode
   AST_SGL_RET: assert property (single_ended_q |-> neg_is_return_q)
      else $error("return unused");
   AST_DIF_PAIR: assert property (!single_ended_q |-> !neg_is_return_q
      && neg_chan_q == (pos_chan_q ^ 3'h1)) else $error("pair wrong");
endmodule // acbd_core_asserts

bind acbd_core acbd_core_asserts u_chk (
   .clk(clk), .nrst(nrst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
   .dout_q(dout_q), .dout_oe_q(dout_oe_q), .track_q(track_q),
   .conversion_strobe_q(conversion_strobe_q), .pos_chan_q(pos_chan_q),
   .neg_chan_q(neg_chan_q), .neg_is_return_q(neg_is_return_q),
   .single_ended_q(single_ended_q), .ext_clock_q(ext_clock_q)
);

// >>> sim/acbd_core_tb_top.sv
`timescale 1ns/1ps
// bench: host frames in, decoded fields and results out
module acbd_core_tb_top;
   reg clk = 1'b0, nrst = 1'b0;
   reg cmp_hi = 1'b0, in_neg = 1'b0, s;
   reg [7:0] vin = 8'h00;
   reg [7:0] b, e;
   reg [23:0] rx, sx;
   integer i, n;
   integer mismatches = 0;
   integer checks_done = 0;
   wire cs_n, sclk, din, dout, strb, dout_oe, strb_oe, dout_line;
   wire [4:0] mode;
   wire [2:0] pos, neg, pos4, neg4;
   wire [7:0] trial;
   // core clock, 4 ns
   always #2 clk = ~clk;
   // comparator: input at or above the trial code
   always @(negedge clk)
      cmp_hi <= (trial <= vin);
   acbd_core #(.EIGHT_CH(1), .STEP_CYCLES(16'h0004)) u_dut (
      .clk(clk), .nrst(nrst), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din), .cmp_hi_pin(cmp_hi), .in_neg_pin(in_neg),
      .dout_q(dout), .dout_oe_q(dout_oe), .conversion_strobe_q(strb),
      .conversion_strobe_oe_q(strb_oe), .pos_chan_q(pos), .neg_chan_q(neg),
      .neg_is_return_q(mode[4]), .coding_unipolar_q(mode[3]),
      .single_ended_q(mode[2]), .powered_q(mode[1]),
      .ext_clock_q(mode[0]), .track_q(), .trial_q(trial)
   );
   // four-channel variant on the same link, routing only
   acbd_core #(.EIGHT_CH(0), .STEP_CYCLES(16'h0004)) u_dut4 (
      .clk(clk), .nrst(nrst), .cs_n_pin(cs_n), .sclk_pin(sclk),
      .din_pin(din), .cmp_hi_pin(cmp_hi), .in_neg_pin(in_neg),
      .dout_q(), .dout_oe_q(), .conversion_strobe_q(),
      .conversion_strobe_oe_q(), .pos_chan_q(pos4), .neg_chan_q(neg4),
      .neg_is_return_q(), .coding_unipolar_q(), .single_ended_q(),
      .powered_q(), .ext_clock_q(), .track_q(), .trial_q()
   );
   // released data line shows the inverse of its last level
   assign dout_line = dout_oe ? dout : ~dout;
   acbd_host u_host (
      .clk(clk), .dout_q(dout_line), .strobe(strb), .cs_n(cs_n),
      .sclk(sclk), .din(din)
   );
   task chk(input [23:0] got, input [23:0] exp);
   begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   // reset, every select code in both modes, then special frames
   initial
   begin
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (10) @(negedge clk);
      for (i = 0; i < 16; i = i + 1)
      begin
         s = i[3];
         b = {1'b1, i[2:0], s | i[0], s, 2'b11};
         vin = 8'h13 * i[7:0] + 8'h07;
         in_neg = ~s & i[1];
         e = (b[3] & in_neg) ? 8'h00 : b[3] ? vin : vin ^ 8'h80;
         u_host.xfer({b, 16'h0000}, rx, sx);
         chk(rx, {10'h000, e, 6'h00});
         chk(sx, (i == 0) ? 24'hFFC000 : 24'h00C000);
         chk({21'h0, pos}, {21'h0, b[5:4], b[6]});
         if (!s)
            chk({21'h0, neg}, {21'h0, b[5:4], ~b[6]});
         chk({19'h0, mode}, {19'h0, s, b[3:0]});
         e = {2'b00, b[5], b[6], 1'b0, b[5], ~b[6]};
         chk({18'h0, pos4, neg4}, {16'h0, e});
         // deselected in external mode: both outputs released, strobe low
         repeat (4) @(negedge clk);
         chk({21'h0, dout_oe, strb_oe, strb}, 24'h0);
         $display("test %0d end", i);
      end
      // two conversions ten shift clocks apart in one frame
      b = 8'hFF;
      vin = 8'hA5;
      u_host.xfer({b, 2'b00, b, 6'h00}, rx, sx);
      chk(rx, {10'h000, vin, 2'b00, vin[7:4]});
      chk(sx, 24'h00C030);
      $display("test back to back end");
      // internal clock after leading zeros; strobe low while busy
      b = 8'hEE;
      vin = 8'h3C;
      u_host.xfer({16'h0000, b}, rx, sx);
      chk({23'h0, strb}, 24'h0);
      for (n = 0; n < 400 && strb !== 1'b1; n = n + 1)
         @(negedge clk);
      chk({22'h0, strb_oe, strb}, 24'h3);
      u_host.xfer(24'h000000, rx, sx);
      chk(rx, {2'b00, vin, 14'h0000});
      chk({21'h0, pos}, 24'h000005);
      $display("test internal end");
      // power-down request with external clock
      u_host.xfer({8'h8D, 16'h0000}, rx, sx);
      chk({22'h0, mode[1:0]}, 24'h000001);
      $display("test power end");
      close_out;
   end
   // frames take about 2 us each; 200 us is far past the sequence
   initial
   begin
      #200000;
      mismatches = mismatches + 1;
      close_out;
   end
endmodule // acbd_core_tb_top

// >>> sim/acbd_host.sv
`timescale 1ns/1ps
// serial host master; shift clock idles low outside frames
module acbd_host (
   input wire clk,
   input wire dout_q,
   input wire strobe,
   output reg cs_n = 1'b1,
   output reg sclk = 1'b0,
   output reg din = 1'b0
);
   // one 24-clock frame, MSB first, data set before each rise
   task xfer(input [23:0] tx, output [23:0] rx, output [23:0] sx);
      integer i;
      begin
         @(negedge clk) cs_n = 1'b0;
         for (i = 23; i >= 0; i = i - 1)
         begin
            din = tx[i];
            repeat (10) @(negedge clk);
            sclk = 1'b1;
            rx[i] = dout_q;
            sx[i] = strobe;
            repeat (10) @(negedge clk);
            sclk = 1'b0;
         end
         repeat (10) @(negedge clk);
         cs_n = 1'b1;
         din = ~din; // released line shows the inverse of its level
      end
   endtask
endmodule // acbd_host
